// >>> src/fcn_pkg.sv
// Purpose: Shared constants for the fabric clock network and delay lock.
// Assumes: One 20 MHz system clock; all clock-like pins are sampled levels.
// Notes: Serial config frame is 16 bits, MSB first.
package fcn_pkg;
  // Clock routing shape
  localparam int FCN_QUADS = 4;
  localparam int FCN_LINES = 12;
  localparam int FCN_MUX_IN = 64;
  localparam int FCN_SEL_W = 6;
  localparam int FCN_LOCAL_IN = 3;
  localparam int FCN_SRC_IN = 60;
  localparam int FCN_PLL_OUTS = 2;
  localparam int FCN_QUAD_OUTS = 3;
  localparam int FCN_DIV_PER_SET = 4;
  // Divider ratio and input source encodings
  localparam logic FCN_DIVIDE_BY_TWO = 1'b0;
  localparam logic FCN_DIVIDE_BY_FOUR = 1'b1;
  localparam logic [1:0] FCN_DSRC_IO = 2'h0;
  localparam logic [1:0] FCN_DSRC_PLL = 2'h1;
  localparam logic [1:0] FCN_DSRC_ROUTE = 2'h2;
  localparam logic [1:0] FCN_CNT_LAST2 = 2'h1;
  localparam logic [1:0] FCN_CNT_LAST4 = 2'h3;
  // Delay loop
  localparam int FCN_CODE_W = 9;
  localparam logic [8:0] FCN_CODE_RST = 9'h080;
  localparam logic [8:0] FCN_CODE_MAX = 9'h1ff;
  localparam int FCN_TAPS = 16;
  localparam int FCN_TAP_SEL_W = 4;
  // Reference source encodings for cascading
  localparam logic [1:0] FCN_REF_PIN = 2'h0;
  localparam logic [1:0] FCN_REF_PLL = 2'h1;
  localparam logic [1:0] FCN_REF_DLL = 2'h2;
  // Serial configuration frame
  localparam int FCN_FRAME_W = 16;
  localparam int FCN_WR_BIT = 15;
  localparam int FCN_ADDR_LO = 12;
  localparam int FCN_DATA_W = 12;
  localparam logic [3:0] FCN_BIT_LAST = 4'hf;
  localparam logic [2:0] FCN_ADDR_CTRL = 3'h0;
  localparam logic [2:0] FCN_ADDR_CODE = 3'h1;
  localparam logic [2:0] FCN_ADDR_STAT = 3'h2;
  // Control word fields and power-up value
  localparam int FCN_CTL_EN = 0;
  localparam int FCN_CTL_REF_LO = 1;
  localparam int FCN_CTL_INT_FB = 3;
  localparam int FCN_CTL_PLL_DLL = 4;
  localparam logic [11:0] FCN_CTRL_RST = 12'h009;
  localparam int FCN_STAT_LOCK = 9;
  // Serial bus states
  typedef enum logic [3:0] {
    FCN_ST_IDLE = 4'b0001,
    FCN_ST_SHIFT = 4'b0010,
    FCN_ST_EXEC = 4'b0100,
    FCN_ST_DONE = 4'b1000
  } fcn_scb_st_t;
endpackage

// >>> src/fcn_gsel.sv
// Purpose: Two-input glitch-free clock selector.
// Assumes: Inputs are already synchronised levels on clk.
// Notes: A switch waits for both inputs to pass a low phase.
`timescale 1ns/1ps
`default_nettype none
module fcn_gsel import fcn_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, low active
  input wire logic in_a, // Candidate clock A
  input wire logic in_b, // Candidate clock B
  input wire logic sel, // 0 picks A, 1 picks B
  output logic out_clk, // Selected clock, registered
  output logic on_b // B currently drives output
);
  logic en_a_q, en_a_d; // A gate open
  logic en_b_q, en_b_d; // B gate open
  logic out_q; // Output flop

  // gates move low-only
  // An enable only changes while its own input is low, so no runt can pass
  always_comb begin
    en_a_d = en_a_q;
    en_b_d = en_b_q;
    if (!in_a) begin
      en_a_d = !sel && !en_b_q;
    end
    if (!in_b) begin
      en_b_d = sel && !en_a_q;
    end
  end

  // Gate and output flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_a_q <= 1'b1;
      en_b_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      en_a_q <= en_a_d;
      en_b_q <= en_b_d;
      out_q <= (in_a & en_a_q) | (in_b & en_b_q);
    end
  end

  assign out_clk = out_q;
  assign on_b = en_b_q;
endmodule
`default_nettype wire

// >>> src/fcn_top.sv
// Purpose: Primary clock muxes, dividers, selectors and delay lock loop.
// Assumes: Clocks from pins and loops arrive as levels sampled on clk.
// Notes: Unused source slots above the populated ones read as zero.
`timescale 1ns/1ps
`default_nettype none
module fcn_top import fcn_pkg::*; #(
  parameter int NUM_PLL = 8, // Phase-locked loops feeding sources
  parameter int NUM_QUAD = 4, // Transceiver quads feeding sources
  parameter int NUM_GSEL = 8, // Glitch-free selectors
  parameter int NUM_DIV = FCN_DIV_PER_SET // Dividers on this edge set
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic rstn, // Async reset, low active
  input wire logic [NUM_PLL*FCN_PLL_OUTS-1:0] pll_out, // PLL outputs
  input wire logic [NUM_QUAD*FCN_QUAD_OUTS-1:0] quad_out, // Quad clocks
  input wire logic [FCN_QUADS*FCN_LOCAL_IN-1:0] prim_local, // Local routing
  input wire logic [FCN_QUADS*FCN_LINES*FCN_SEL_W-1:0] prim_sel, // Line selects
  output logic [FCN_QUADS*FCN_LINES-1:0] prim_clk, // Primary lines
  input wire logic [NUM_DIV-1:0] div_io_in, // Divider io inputs
  input wire logic [NUM_DIV-1:0] div_pll_in, // Divider PLL inputs
  input wire logic [NUM_DIV-1:0] div_route_in, // Divider routing inputs
  input wire logic [NUM_DIV*2-1:0] div_src, // Divider source selects
  input wire logic [NUM_DIV-1:0] div_ratio, // 0 two, 1 four
  input wire logic [NUM_DIV-1:0] div_rst, // Divider resets, high
  output logic [NUM_DIV-1:0] div_clk, // Divided clocks
  output logic [NUM_DIV-1:0] edge_set_reset, // Gearing set/reset
  input wire logic [NUM_GSEL-1:0] gsel_in_a, // Selector clock A
  input wire logic [NUM_GSEL-1:0] gsel_in_b, // Selector clock B
  input wire logic [NUM_GSEL-1:0] gsel_sel, // Selector choice
  output logic [NUM_GSEL-1:0] gsel_clk, // Selector outputs
  output logic [NUM_GSEL-1:0] gsel_on_b, // Selector on input B
  input wire logic dll_ref_pin, // Loop reference pin
  input wire logic dll_fb_pin, // External feedback pin
  input wire logic pll_casc_in, // PLL output into loop
  input wire logic dll_casc_in, // Other loop output
  output logic dll_casc_out, // Delayed clock out
  output logic pll_ref_out, // Reference for next PLL
  output logic [FCN_CODE_W-1:0] delay_code_bus, // Broadcast code
  output logic [FCN_CODE_W-1:0] bank_lo_code, // Lower bank copy
  output logic [FCN_CODE_W-1:0] bank_hi_code, // Upper bank copy
  input wire logic delay_code_latch, // Hold request, high
  output logic [FCN_CODE_W-1:0] delay_code_held, // Held code
  output logic dll_lock, // Loop dithering about lock
  input wire logic mp_sel, // Port serial select
  input wire logic mp_sclk, // Port serial clock
  input wire logic mp_sdi, // Port serial data in
  input wire logic rt_sel, // Routing serial select
  input wire logic rt_sclk, // Routing serial clock
  input wire logic rt_sdi, // Routing serial data in
  input wire logic scb_from_routing, // Use routing serial pins
  output logic serial_config_bus_sdo // Serial data out
);
  // Widths of assembled vectors
  localparam int PLL_W = NUM_PLL * FCN_PLL_OUTS;
  localparam int QUAD_W = NUM_QUAD * FCN_QUAD_OUTS;
  localparam int USED = PLL_W + NUM_DIV + NUM_GSEL + QUAD_W;
  localparam int AS_W = PLL_W + QUAD_W + 2 * NUM_DIV + 2 * NUM_GSEL + 7;

  // Rising edge seen between two samples
  function automatic logic fn_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Step a code by one tap, saturating at both ends
  function automatic logic [FCN_CODE_W-1:0] fn_step(
    input logic [FCN_CODE_W-1:0] c, input logic down);
    if (down) begin
      return (c == '0) ? c : c - 1'b1;
    end
    return (c == FCN_CODE_MAX) ? c : c + 1'b1;
  endfunction

  logic [1:0] rst_sync_q; // Reset release chain
  logic rst_n; // Synchronised reset
  logic [AS_W-1:0] as_raw; // All off-domain inputs
  logic [AS_W-1:0] as_s1_q; // First sync stage
  logic [AS_W-1:0] as_s2_q; // Second sync stage

  // Reset is asserted at once, released on clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Off-domain levels, two flops before any use
  assign as_raw = {pll_out, quad_out, div_io_in, div_pll_in, gsel_in_a,
                   gsel_in_b, dll_ref_pin, dll_fb_pin, pll_casc_in,
                   dll_casc_in, mp_sel, mp_sclk, mp_sdi};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      as_s1_q <= '0;
      as_s2_q <= '0;
    end else begin
      as_s1_q <= as_raw;
      as_s2_q <= as_s1_q;
    end
  end

  // Named slices of the synchronised vector
  wire [PLL_W-1:0] pll_s = as_s2_q[AS_W-1 -: PLL_W];
  wire [QUAD_W-1:0] quad_s = as_s2_q[AS_W-PLL_W-1 -: QUAD_W];
  wire [NUM_DIV-1:0] dio_s = as_s2_q[AS_W-PLL_W-QUAD_W-1 -: NUM_DIV];
  wire [NUM_DIV-1:0] dpll_s = as_s2_q[AS_W-PLL_W-QUAD_W-NUM_DIV-1 -: NUM_DIV];
  wire [NUM_GSEL-1:0] ga_s = as_s2_q[2*NUM_GSEL+6 -: NUM_GSEL];
  wire [NUM_GSEL-1:0] gb_s = as_s2_q[NUM_GSEL+6 -: NUM_GSEL];
  wire ref_pin_s = as_s2_q[6];
  wire fb_pin_s = as_s2_q[5];
  wire pll_casc_s = as_s2_q[4];
  wire dll_casc_s = as_s2_q[3];
  wire mp_sel_s = as_s2_q[2];
  wire mp_sclk_s = as_s2_q[1];
  wire mp_sdi_s = as_s2_q[0];

  // primary source set
  // Order: PLL pairs, dividers, selectors, quad triples, then zero fill
  logic [FCN_SRC_IN-1:0] src_set;
  assign src_set = {{(FCN_SRC_IN-USED){1'b0}}, quad_s, gsel_clk, div_clk, pll_s};

  for (genvar q = 0; q < FCN_QUADS; q++) begin : g_quad
    for (genvar l = 0; l < FCN_LINES; l++) begin : g_line
      localparam int IDX = q * FCN_LINES + l;
      wire [FCN_MUX_IN-1:0] cand = {src_set, 1'b0,
                                    prim_local[q*FCN_LOCAL_IN +: FCN_LOCAL_IN]};
      wire [FCN_SEL_W-1:0] pick = prim_sel[IDX*FCN_SEL_W +: FCN_SEL_W];
      logic line_q; // Registered line level
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          line_q <= 1'b0;
        end else begin
          line_q <= cand[pick];
        end
      end
      assign prim_clk[IDX] = line_q;
    end
  end

  for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
    logic in_prev_q; // Last input sample
    logic [1:0] cnt_q; // Phase counter
    logic out_q; // Divided level
    logic sr_q; // Edge set/reset level
    logic arm_q; // Waiting for first wrap
    logic div_in; // Selected input level
    assign div_in = (div_src[2*i +: 2] == FCN_DSRC_IO) ? dio_s[i] :
                    (div_src[2*i +: 2] == FCN_DSRC_PLL) ? dpll_s[i] :
                    (div_src[2*i +: 2] == FCN_DSRC_ROUTE) ? div_route_in[i] : 1'b0;
    wire rise = fn_rise(div_in, in_prev_q);
    wire [1:0] last = (div_ratio[i] == FCN_DIVIDE_BY_FOUR) ? FCN_CNT_LAST4 :
                      FCN_CNT_LAST2;
    wire [1:0] cnt_nx = (cnt_q == last) ? 2'h0 : cnt_q + 2'h1;

    // Counter, output and set/reset per divider
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        in_prev_q <= 1'b0;
        cnt_q <= 2'h0;
        out_q <= 1'b0;
        sr_q <= 1'b0;
        arm_q <= 1'b1;
      end else begin
        in_prev_q <= div_in;
        if (div_rst[i]) begin
          cnt_q <= 2'h0;
          out_q <= 1'b0;
          sr_q <= 1'b0;
          arm_q <= 1'b1;
        end else begin
          // set/reset until first wrap
          // Gearing logic stays cleared for one whole divided period
          sr_q <= arm_q;
          if (rise) begin
            cnt_q <= cnt_nx;
            out_q <= (div_ratio[i] == FCN_DIVIDE_BY_FOUR) ? cnt_nx[1] : cnt_nx[0];
            if (cnt_nx == 2'h0) begin
              arm_q <= 1'b0;
              sr_q <= 1'b0;
            end
          end
        end
      end
    end
    assign div_clk[i] = out_q;
    assign edge_set_reset[i] = sr_q;
  end

  for (genvar g = 0; g < NUM_GSEL; g++) begin : g_gsel
    fcn_gsel u_gsel (
      .clk(clk),
      .rst_n(rst_n),
      .in_a(ga_s[g]),
      .in_b(gb_s[g]),
      .sel(gsel_sel[g]),
      .out_clk(gsel_clk[g]),
      .on_b(gsel_on_b[g])
    );
  end

  // Delay loop state
  logic [FCN_DATA_W-1:0] ctrl_q; // Loop control word
  logic [FCN_CODE_W-1:0] code_q; // Delay code
  logic [FCN_CODE_W-1:0] held_q; // Latched code
  logic [FCN_TAPS-1:0] tap_q; // Own delay chain
  logic dly_q; // Chain output
  logic ref_prev_q; // Last reference sample
  logic dir_q; // Last step was down
  logic lock_q; // Direction reversed
  logic pll_ref_q; // Next PLL reference
  logic dll_ref; // Chosen reference
  logic dll_fb; // Chosen feedback

  // cascade source selection
  // Reference from pin, a PLL output, or another loop
  assign dll_ref = (ctrl_q[FCN_CTL_REF_LO +: 2] == FCN_REF_PLL) ? pll_casc_s :
                   (ctrl_q[FCN_CTL_REF_LO +: 2] == FCN_REF_DLL) ? dll_casc_s :
                   ref_pin_s;
  assign dll_fb = ctrl_q[FCN_CTL_INT_FB] ? dly_q : fb_pin_s;
  wire ref_rise = fn_rise(dll_ref, ref_prev_q);
  wire step_down = dll_fb;

  // Serial bus state
  fcn_scb_st_t st_q; // Serial state
  logic [FCN_FRAME_W-1:0] rx_q; // Incoming frame
  logic [FCN_FRAME_W-1:0] tx_q; // Outgoing frame
  logic [3:0] bit_q; // Bits taken
  logic sclk_prev_q; // Last serial clock
  // routing drives the bus
  // Routing pins are fabric logic on clk, so they need no sync
  wire s_sel = scb_from_routing ? rt_sel : mp_sel_s;
  wire s_clk = scb_from_routing ? rt_sclk : mp_sclk_s;
  wire s_din = scb_from_routing ? rt_sdi : mp_sdi_s;
  wire s_rise = fn_rise(s_clk, sclk_prev_q);
  wire [2:0] f_addr = rx_q[FCN_WR_BIT-1 -: 3];
  wire f_wr = rx_q[FCN_WR_BIT];
  wire do_wr = (st_q == FCN_ST_EXEC) && f_wr;
  wire [FCN_DATA_W-1:0] stat_w = {2'h0, lock_q, code_q};
  wire [FCN_DATA_W-1:0] rd_data =
    (f_addr == FCN_ADDR_CTRL) ? ctrl_q :
    (f_addr == FCN_ADDR_CODE) ? {3'h0, code_q} :
    (f_addr == FCN_ADDR_STAT) ? stat_w : '0;

  // serial reconfiguration
  // Aborts cleanly if select drops mid-frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FCN_ST_IDLE;
      rx_q <= '0;
      tx_q <= '0;
      bit_q <= 4'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= s_clk;
      case (st_q)
        FCN_ST_IDLE: begin
          bit_q <= 4'h0;
          if (s_sel) begin
            st_q <= FCN_ST_SHIFT;
          end
        end
        FCN_ST_SHIFT: begin
          if (!s_sel) begin
            st_q <= FCN_ST_IDLE;
          end else if (s_rise) begin
            rx_q <= {rx_q[FCN_FRAME_W-2:0], s_din};
            tx_q <= {tx_q[FCN_FRAME_W-2:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            if (bit_q == FCN_BIT_LAST) begin
              st_q <= FCN_ST_EXEC;
            end
          end
        end
        FCN_ST_EXEC: begin
          // Read data goes out in the next frame
          if (!f_wr) begin
            tx_q <= {4'h0, rd_data};
          end
          st_q <= FCN_ST_DONE;
        end
        FCN_ST_DONE: begin
          if (!s_sel) begin
            st_q <= FCN_ST_IDLE;
          end
        end
        default: begin
          st_q <= FCN_ST_IDLE;
        end
      endcase
    end
  end

  // Control word, power-up value then serial writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= FCN_CTRL_RST;
    end else if (do_wr && (f_addr == FCN_ADDR_CTRL)) begin
      ctrl_q <= rx_q[FCN_DATA_W-1:0];
    end
  end

  // one tap per step
  // A serial code write wins over a step in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= FCN_CODE_RST;
      ref_prev_q <= 1'b0;
      dir_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      ref_prev_q <= dll_ref;
      if (do_wr && (f_addr == FCN_ADDR_CODE)) begin
        code_q <= rx_q[FCN_CODE_W-1:0];
        lock_q <= 1'b0;
      end else if (!ctrl_q[FCN_CTL_EN]) begin
        lock_q <= 1'b0;
      end else if (ref_rise) begin
        code_q <= fn_step(code_q, step_down);
        dir_q <= step_down;
        if (dir_q != step_down) begin
          lock_q <= 1'b1;
        end
      end
    end
  end

  // code sets chain
  // Coarse model: top code bits pick one of the chain taps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= '0;
      dly_q <= 1'b0;
      pll_ref_q <= 1'b0;
    end else begin
      tap_q <= {tap_q[FCN_TAPS-2:0], dll_ref};
      dly_q <= tap_q[code_q[FCN_CODE_W-1 -: FCN_TAP_SEL_W]];
      pll_ref_q <= ctrl_q[FCN_CTL_PLL_DLL] ? dly_q : pll_casc_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= FCN_CODE_RST;
    end else if (delay_code_latch) begin
      held_q <= code_q;
    end
  end

  assign delay_code_bus = code_q;
  assign bank_lo_code = code_q;
  assign bank_hi_code = code_q;
  assign delay_code_held = held_q;
  assign dll_casc_out = dly_q;
  assign pll_ref_out = pll_ref_q;
  assign dll_lock = lock_q;
  assign serial_config_bus_sdo = tx_q[FCN_FRAME_W-1];
endmodule
`default_nettype wire

// >>> testbench/fcn_top_assertions.sv
// Purpose: Port checks for the clock network top.
// Assumes: One clk domain; rstn low active.
// Notes: Code steps judged only while serial pins idle.
`timescale 1ns/1ps
`default_nettype none
module fcn_top_chk import fcn_pkg::*; #(
  parameter int NUM_DIV = FCN_DIV_PER_SET, // Dividers
  parameter int NUM_GSEL = 8 // Selectors
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Reset, low active
  input wire logic [FCN_QUADS*FCN_LOCAL_IN-1:0] prim_local, // Local routing
  input wire logic [FCN_QUADS*FCN_LINES*FCN_SEL_W-1:0] prim_sel, // Line selects
  input wire logic [FCN_QUADS*FCN_LINES-1:0] prim_clk, // Primary lines
  input wire logic [NUM_DIV-1:0] div_rst, // Divider resets
  input wire logic [NUM_DIV-1:0] div_clk, // Divided clocks
  input wire logic [NUM_DIV-1:0] edge_set_reset, // Gearing set/reset
  input wire logic [NUM_GSEL-1:0] gsel_sel, // Selector choice
  input wire logic [NUM_GSEL-1:0] gsel_on_b, // Selector on B
  input wire logic [FCN_CODE_W-1:0] delay_code_bus, // Code
  input wire logic [FCN_CODE_W-1:0] bank_lo_code, // Lower copy
  input wire logic [FCN_CODE_W-1:0] bank_hi_code, // Upper copy
  input wire logic delay_code_latch, // Hold request
  input wire logic [FCN_CODE_W-1:0] delay_code_held, // Held code
  input wire logic rt_sel, // Routing select
  input wire logic mp_sel // Port select
);
  // All checks on clk, quiet in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_DIV_HOLD: assert property (div_rst[0] |=> !div_clk[0] && !edge_set_reset[0])
    else $error("divider active in reset");
  AST_ESR_START: assert property ($fell(div_rst[0]) |=> edge_set_reset[0])
    else $error("set/reset not raised on release");
  AST_ESR_WRAP: assert property ($fell(edge_set_reset[1]) |-> !div_clk[1])
    else $error("set/reset dropped off the wrap");
  AST_LATCH_CAP: assert property (delay_code_latch |=>
    delay_code_held == $past(delay_code_bus))
    else $error("latch missed code");
  AST_LATCH_HOLD: assert property (!delay_code_latch |=> $stable(delay_code_held))
    else $error("held code moved");
  AST_BANK_COPY: assert property (bank_lo_code == delay_code_bus &&
    bank_hi_code == delay_code_bus)
    else $error("bank copy differs");
  // Serial idle means only the loop may move the code
  AST_ONE_TAP: assert property ($changed(delay_code_bus) && !rt_sel && !$past(rt_sel)
    && !mp_sel |-> delay_code_bus - $past(delay_code_bus) == 9'h001 ||
    $past(delay_code_bus) - delay_code_bus == 9'h001)
    else $error("code moved more than one tap");
  AST_GND: assert property (prim_sel[5:0] == 6'h03 |=> !prim_clk[0])
    else $error("ground input not zero");
  AST_LOCAL: assert property (prim_sel[11:6] == 6'h01 |=>
    prim_clk[1] == $past(prim_local[1]))
    else $error("local input not passed");
  AST_GSEL_B: assert property ($rose(gsel_sel[0]) |-> ##[1:60] gsel_on_b[0])
    else $error("selector never moved to B");
  AST_GSEL_CAUSE: assert property ($rose(gsel_on_b[0]) |-> $past(gsel_sel[0]))
    else $error("selector moved unasked");
endmodule
bind fcn_top fcn_top_chk #(.NUM_DIV(NUM_DIV), .NUM_GSEL(NUM_GSEL)) i_chk (
  .clk, .rstn, .prim_local, .prim_sel, .prim_clk, .div_rst, .div_clk, .edge_set_reset,
  .gsel_sel, .gsel_on_b, .delay_code_bus, .bank_lo_code, .bank_hi_code,
  .delay_code_latch, .delay_code_held, .rt_sel, .mp_sel
);
`default_nettype wire

// >>> testbench/fcn_fabric_model.sv
// Purpose: Fabric logic driving routing serial pins and a routing clock.
// Assumes: Called at falling edges of clk.
// Notes: Serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module fcn_fabric_model (
  input wire logic clk, // System clock
  output logic rt_sel, // Serial select
  output logic rt_sclk, // Serial clock
  output logic rt_sdi, // Serial data
  output logic route_clk // Clock from routing
);
  // Idle lines at time zero
  initial begin
    {rt_sel, rt_sclk, rt_sdi, route_clk} = 4'h0;
  end

  task automatic send(input logic [15:0] f, input int slow);
    rt_sel = 1'b1;
    for (int b = 15; b >= 0; b--) begin
      rt_sdi = f[b];
      repeat (2 + slow) @(negedge clk);
      rt_sclk = 1'b1;
      repeat (2 + slow) @(negedge clk);
      rt_sclk = 1'b0;
    end
    // Let the write land before dropping select
    repeat (4) @(negedge clk);
    rt_sel = 1'b0;
    rt_sdi = ~rt_sdi; // Released data is not held
    repeat (2) @(negedge clk);
  endtask

  task automatic burst(input int n);
    repeat (n) begin
      repeat (3) @(negedge clk);
      route_clk = 1'b1;
      repeat (3) @(negedge clk);
      route_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_fcn_top.sv
// Purpose: Directed test of the clock network top.
// Assumes: Fabric model drives routing serial pins.
// Notes: Async pins are given several cycles to sync.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("wrong value at %0t: %0h vs %0h", $time, (a), (e)); \
  end \
end
module test_fcn_top import fcn_pkg::*;;
  logic clk, rstn, fb, latch, scb_rt, mon, gprev; // Single pins
  logic [15:0] pll_out; // PLL levels
  logic [11:0] quad_out, prim_local; // Quad and local levels
  logic [287:0] prim_sel; // Line selects
  logic [47:0] prim_clk; // Primary lines
  logic [7:0] div_src, gsel_sel, gsel_clk, gsel_on_b; // Divider, selector
  logic [3:0] div_ratio, div_rst, div_clk, esr, dprev, eprev, tick; // Divider pins
  logic [2:0] refs; // Reference pulses
  logic [8:0] code, code_bus, lo_code, hi_code, held; // Delay codes
  logic rt_sel, rt_sclk, rt_sdi, route_clk; // Fabric model pins
  logic casc, pref, lock, sdo; // Loop and serial outputs
  logic [15:0] sdo_cap; // Bits seen on sdo
  int failures = 0, n_tests = 0, grun = 0; // Counters
  int n_div[4], n_esr[4]; // Divider event counts

  fcn_top i_dut (
    .clk, .rstn, .pll_out, .quad_out, .prim_local, .prim_sel, .prim_clk,
    .div_io_in({4{route_clk}}), .div_pll_in({4{route_clk}}), .div_route_in({4{route_clk}}),
    .div_src, .div_ratio, .div_rst, .div_clk, .edge_set_reset(esr),
    .gsel_in_a({8{tick[2]}}), .gsel_in_b({8{tick[3]}}), .gsel_sel, .gsel_clk, .gsel_on_b,
    .dll_ref_pin(refs[0]), .dll_fb_pin(fb), .pll_casc_in(refs[1]), .dll_casc_in(refs[2]),
    .dll_casc_out(casc), .pll_ref_out(pref), .delay_code_bus(code_bus), .bank_lo_code(lo_code),
    .bank_hi_code(hi_code), .delay_code_latch(latch), .delay_code_held(held), .dll_lock(lock),
    // Port serial pins share the fabric wires, seen behind their sync
    .mp_sel(rt_sel), .mp_sclk(rt_sclk), .mp_sdi(rt_sdi), .rt_sel, .rt_sclk, .rt_sdi,
    .scb_from_routing(scb_rt), .serial_config_bus_sdo(sdo)
  );
  fcn_fabric_model i_fab (.clk, .rt_sel, .rt_sclk, .rt_sdi, .route_clk);

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Slow selector test clocks
  always @(negedge clk) tick <= tick + 4'h1;

  // Read data leaves on sdo, one bit per serial clock rise
  always @(posedge rt_sclk) sdo_cap <= {sdo_cap[14:0], sdo};

  // Divider edges and selector run lengths, sampled once settled
  always @(negedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (div_clk[k] && !dprev[k]) n_div[k]++;
      if (!esr[k] && eprev[k]) n_esr[k]++;
    end
    dprev <= div_clk;
    eprev <= esr;
    if (gsel_clk[0] !== gprev) begin
      if (mon) `CHK(grun >= 4, 1'b1)
      grun = 1;
    end else begin
      grun++;
    end
    gprev = gsel_clk[0];
  end

  // Expected level of a line for a given select
  function automatic logic exp_line(input int i, input int s);
    if (s < 3) return prim_local[(i / 12) * 3 + s];
    if (s >= 4 && s < 20) return pll_out[s - 4];
    if (s >= 32 && s < 44) return quad_out[s - 32];
    return 1'b0;
  endfunction

  // Set every line from one source band, then compare
  task automatic mux_case(input int base, input int md);
    for (int i = 0; i < 48; i++)
      prim_sel[i*6 +: 6] = 6'(base + i % md);
    repeat (6) @(negedge clk);
    for (int i = 0; i < 48; i++)
      `CHK(prim_clk[i], exp_line(i, base + i % md))
  endtask

  // Pulse one reference with a chosen feedback level
  task automatic step(input int r, input logic f);
    fb = f;
    refs[r] = 1'b1;
    repeat (4) @(negedge clk);
    refs[r] = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic results;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    {rstn, fb, latch, scb_rt, mon, gprev, refs, tick, dprev, eprev} = '0;
    {pll_out, quad_out, prim_local, prim_sel, div_src, gsel_sel, div_ratio} = '0;
    div_rst = 4'hf;
    repeat (10) @(negedge clk);
    `CHK({code_bus, held}, {2{FCN_CODE_RST}})
    `CHK({div_clk, gsel_on_b}, 12'h000)
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    scb_rt = 1'b1;
    repeat (4) @(negedge clk);
    // Primary mux bands: local, ground, PLL, quad, empty
    pll_out = 16'hc3a5;
    quad_out = 12'h96c;
    prim_local = 12'ha5c;
    mux_case(0, 3);
    mux_case(3, 1);
    mux_case(4, 16);
    mux_case(32, 12);
    mux_case(44, 20);
    mon = 1'b1;
    // Dividers by two and four, from routing, PLL and io
    div_src = 8'h1a;
    div_ratio = 4'b1010;
    n_div = '{default: 0};
    n_esr = '{default: 0};
    i_fab.burst(2);
    `CHK(n_div[0] + n_div[1] + n_div[2] + n_div[3], 0)
    div_rst = 4'h0;
    i_fab.burst(8);
    repeat (10) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      `CHK(n_div[k], div_ratio[k] ? 2 : 4)
      `CHK(n_esr[k], 1)
    end
    `CHK(div_clk, 4'h0)
    // Loop reference from pin, PLL and another loop
    code = FCN_CODE_RST;
    // Last pass also feeds the delayed clock to the next PLL
    for (int r = 0; r < 3; r++) begin
      i_fab.send({1'b1, FCN_ADDR_CTRL, 8'(r / 2), 4'(1 + 2 * r)}, r);
      step(r, r[0]);
      code = r[0] ? code - 9'h001 : code + 9'h001;
      `CHK({code_bus, casc, pref}, {code, 1'b1, r == 2})
    end
    `CHK(lock, 1'b1)
    // Status read, shifted out during the next frame over the port pins
    i_fab.send({1'b0, FCN_ADDR_STAT, 12'h000}, 0);
    scb_rt = 1'b0;
    // Disabled loop ignores reference; slow serial code write
    i_fab.send({1'b1, FCN_ADDR_CTRL, 12'h000}, 0);
    `CHK(sdo_cap, {7'h01, code})
    scb_rt = 1'b1;
    step(0, 1'b0);
    `CHK({code_bus, lock}, {code, 1'b0})
    i_fab.send({1'b1, FCN_ADDR_CODE, 12'h1a5}, 3);
    `CHK({code_bus, lo_code, hi_code}, {3{9'h1a5}})
    latch = 1'b1;
    @(negedge clk);
    latch = 1'b0;
    i_fab.send({1'b1, FCN_ADDR_CODE, 12'h033}, 0);
    `CHK({held, code_bus}, {9'h1a5, 9'h033})
    // Selector switching both ways
    gsel_sel = 8'hff;
    repeat (60) @(negedge clk);
    `CHK(gsel_on_b, 8'hff)
    gsel_sel = 8'h00;
    repeat (60) @(negedge clk);
    `CHK(gsel_on_b, 8'h00)
    results();
  end
endmodule
`default_nettype wire
